// file: src/fppc_ctrl.sv
/*
 * fppc_ctrl: flash program, erase and protection controller with AXI4-Lite registers.
 * Assumes i_por_n only at power-up (stand-in for nonvolatile keep), i_rst_n as chip reset.
 */
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fppc_ctrl
	import fppc_pkg::*;
(
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_por_n,
	input  wire logic            i_awvalid,
	output logic                 o_awready,
	input  wire logic [7:0]      i_awaddr,
	input  wire logic            i_wvalid,
	output logic                 o_wready,
	input  wire logic [31:0]     i_wdata,
	input  wire logic [3:0]      i_wstrb,
	output logic                 o_bvalid,
	input  wire logic            i_bready,
	output logic [1:0]           o_bresp,
	input  wire logic            i_arvalid,
	output logic                 o_arready,
	input  wire logic [7:0]      i_araddr,
	output logic                 o_rvalid,
	input  wire logic            i_rready,
	output logic [31:0]          o_rdata,
	output logic [1:0]           o_rresp,
	input  wire fppc_rd_req_type i_rd_req,
	output fppc_rd_rsp_type      o_rd_rsp,
	output logic                 o_busy,
	output logic                 o_irq
);
	// bus slave state
	logic        aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q, rresp_q;
	// software-visible state
	logic [BADDR_W-1:0] addr_q;   // flash byte address
	logic [31:0]        data_q;   // program data
	logic [7:0]         usec_q;   // clocks per microsecond
	logic [PBLK_W-1:0]  psel_q;   // selected protection block
	logic [1:0]         raw_q;    // sticky flags
	logic [1:0]         msk_q;    // flag enables
	logic               err_q;    // last command or protection change refused
	logic [31:0]        user_vol_q [2];
	logic [31:0]        user_nv_q  [2];
	logic               usaved_q, psaved_q;
	fppc_prot_type      prot_vol_q [PROT_BLKS];
	fppc_prot_type      prot_nv_q  [PROT_BLKS];
	fppc_prot_type      prot_eff   [PROT_BLKS];
	// sequencer
	fppc_state_type     st_q, st_d;
	logic [EIDX_W-1:0]  eidx_q;   // erase word index
	logic [15:0]        wait_q;   // remaining wait cycles
	logic [15:0]        wait_us_q;
	logic               op_flash_q; // current op is erase or program
	logic               busy_q, irq_q;
	// read port pipeline
	logic               rq_valid_q, rq_deny_q;
	fppc_rd_rsp_type    rsp_q;
	// memory wiring
	logic [31:0]        mem_a_data, mem_b_data, mem_wdata;
	logic [WADDR_W-1:0] mem_waddr;
	logic               mem_we;

	// register read value by offset; protection shows the effective level
	function automatic logic [31:0] reg_value(input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		if (a == OFS_CTRL) begin
			v[STA_BUSY]   = busy_q;
			v[STA_ERR]    = err_q;
			v[STA_PSAVED] = psaved_q;
			v[STA_USAVED] = usaved_q;
		end else if (a == OFS_ADDR) begin
			v[BADDR_W-1:0] = addr_q;
		end else if (a == OFS_DATA) begin
			v = data_q;
		end else if (a == OFS_USEC) begin
			v[7:0] = usec_q;
		end else if (a == OFS_PSEL) begin
			v[PBLK_W-1:0] = psel_q;
		end else if (a == OFS_PROT) begin
			v[1:0] = prot_eff[psel_q];
		end else if (a == OFS_IRAW) begin
			v[1:0] = raw_q;
		end else if (a == OFS_IMSK) begin
			v[1:0] = msk_q;
		end else if (a == OFS_IMIS) begin
			v[1:0] = raw_q & msk_q;
		end else if (a == OFS_USR0) begin
			v = usaved_q ? user_nv_q[0] : user_vol_q[0];
		end else if (a == OFS_USR1) begin
			v = usaved_q ? user_nv_q[1] : user_vol_q[1];
		end
		return v;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a <= OFS_USR1) && (a[1:0] == 2'h0);
	endfunction

	// write decode helpers
	logic        wr_go, aw_take, w_take, ar_take;
	logic [31:0] wmask, wd;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wstrb_q[i]}};
		end
	end
	assign aw_take = i_awvalid && awready_q;
	assign w_take  = i_wvalid && wready_q;
	assign ar_take = i_arvalid && arready_q;
	assign wr_go   = aw_full_q && w_full_q && !bvalid_q;
	assign wd      = (reg_value(awaddr_q) & ~wmask) | (wdata_q & wmask);

	// command decode, only in idle; protection writes in any state
	logic cmd_wr, blk_full, go_prog, go_erase, refuse, psave_go, usave_go, pset_go, pset_ok;
	fppc_prot_type pset_val;
	assign cmd_wr   = wr_go && (awaddr_q == OFS_CTRL) && (st_q == st_idle);
	assign blk_full = (prot_eff[addr_q[BADDR_W-1 -: PBLK_W]] == prot_full_access);
	assign go_prog  = cmd_wr && wd[CTL_PROG] && blk_full;
	assign go_erase = cmd_wr && !wd[CTL_PROG] && wd[CTL_ERASE] && blk_full;
	assign refuse   = cmd_wr && (wd[CTL_PROG] || wd[CTL_ERASE]) && !blk_full;
	assign psave_go = cmd_wr && !wd[CTL_PROG] && !wd[CTL_ERASE] && wd[CTL_PSAVE];
	assign usave_go = cmd_wr && !wd[CTL_PROG] && !wd[CTL_ERASE] && wd[CTL_USAVE];
	assign pset_go  = wr_go && (awaddr_q == OFS_PROT);
	assign pset_val = fppc_prot_type'(wd[1:0]);
	// tighten only; fetch-only blocks accept nothing
	assign pset_ok  = (wd[1:0] != 2'b11) && ((pset_val > prot_eff[psel_q]) ||
		((pset_val == prot_eff[psel_q]) && (prot_eff[psel_q] != prot_fetch_only)));

	// AXI4-Lite write channels and response
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= i_awaddr;
				awready_q <= 1'b0;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wdata_q  <= i_wdata;
				wstrb_q  <= i_wstrb;
				wready_q <= 1'b0;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && i_bready) begin
				// address and data accepted again only after the response
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel, one read under way at a time
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= reg_value(i_araddr);
			rresp_q   <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && i_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// plain software registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_q <= '0;
			data_q <= '0;
			usec_q <= USEC_RST;
			psel_q <= '0;
			msk_q  <= '0;
		end else if (wr_go) begin
			if (awaddr_q == OFS_ADDR) begin
				addr_q <= wd[BADDR_W-1:0]; // low bits ignored by the sequencer
			end else if (awaddr_q == OFS_DATA) begin
				data_q <= wd;
			end else if (awaddr_q == OFS_USEC) begin
				usec_q <= wd[7:0];
			end else if (awaddr_q == OFS_PSEL) begin
				psel_q <= wd[PBLK_W-1:0];
			end else if (awaddr_q == OFS_IMSK) begin
				msk_q <= wd[1:0];
			end
		end
	end

	// per-block protection: volatile part falls back at chip reset, committed part does not
	for (genvar b = 0; b < PROT_BLKS; b++) begin : g_prot
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				prot_vol_q[b] <= prot_full_access;
			end else if (pset_go && pset_ok && (psel_q == PBLK_W'(b))) begin
				prot_vol_q[b] <= pset_val;
			end
		end
		always_ff @(posedge i_clk or negedge i_por_n) begin
			if (!i_por_n) begin
				prot_nv_q[b] <= prot_full_access;
			end else if (psave_go) begin
				prot_nv_q[b] <= prot_eff[b];
			end
		end
		assign prot_eff[b] = (prot_vol_q[b] > prot_nv_q[b]) ? prot_vol_q[b] : prot_nv_q[b];
	end

	// user registers: writes ignored once committed
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			user_vol_q[0] <= USER_RST;
			user_vol_q[1] <= USER_RST;
		end else if (wr_go && !usaved_q) begin
			if (awaddr_q == OFS_USR0) begin
				user_vol_q[0] <= wd;
			end else if (awaddr_q == OFS_USR1) begin
				user_vol_q[1] <= wd;
			end
		end
	end

	// committed copies, survive chip reset
	always_ff @(posedge i_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			user_nv_q[0] <= USER_RST;
			user_nv_q[1] <= USER_RST;
			usaved_q     <= 1'b0;
			psaved_q     <= 1'b0;
		end else begin
			if (usave_go && !usaved_q) begin
				user_nv_q[0] <= user_vol_q[0];
				user_nv_q[1] <= user_vol_q[1];
				usaved_q     <= 1'b1;
			end
			if (psave_go) begin
				psaved_q <= 1'b1;
			end
		end
	end

	// sequencer next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			st_idle: begin
				if (go_prog) begin
					st_d = st_prd;
				end else if (go_erase) begin
					st_d = st_erase;
				end else if (psave_go || usave_go) begin
					st_d = st_wait;
				end
			end
			st_prd:   st_d = st_pwr;
			st_pwr:   st_d = st_wait;
			st_erase: if (&eidx_q) st_d = st_wait;
			st_wait:  if (wait_q <= 16'h0001) st_d = st_idle;
			default:  st_d = st_idle;
		endcase
	end

	// sequencer registers; wait scaled by clocks per microsecond
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q       <= st_idle;
			eidx_q     <= '0;
			wait_q     <= '0;
			wait_us_q  <= '0;
			op_flash_q <= 1'b0;
			busy_q     <= 1'b0;
		end else begin
			st_q   <= st_d;
			busy_q <= (st_d != st_idle);
			if (st_q == st_idle) begin
				eidx_q     <= '0;
				op_flash_q <= go_prog || go_erase;
				wait_us_q  <= go_prog ? PROG_TIME_US : (go_erase ? ERASE_TIME_US : SAVE_TIME_US);
			end else if (st_q == st_erase) begin
				eidx_q <= eidx_q + 1'b1;
			end
			if ((st_d == st_wait) && (st_q != st_wait)) begin
				wait_q <= {8'h00, usec_q} * wait_us_q;
			end else if (st_q == st_wait) begin
				wait_q <= wait_q - 16'h0001;
			end
		end
	end

	// error status: refused command or rejected protection change
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_q <= 1'b0;
		end else if (refuse || (pset_go && !pset_ok)) begin
			err_q <= 1'b1;
		end else if (cmd_wr || pset_go) begin
			err_q <= 1'b0;
		end
	end

	// array write path: erase fills ones, program merges by AND
	assign mem_we    = (st_q == st_pwr) || (st_q == st_erase);
	assign mem_waddr = (st_q == st_erase) ? {addr_q[BADDR_W-1 -: 4], eidx_q} : addr_q[BADDR_W-1:2];
	assign mem_wdata = (st_q == st_erase) ? ERASED_WORD : (mem_b_data & data_q);

	fppc_mem u_mem (
		.i_clk     (i_clk),
		.i_ra_addr (i_rd_req.addr[BADDR_W-1:2]),
		.o_ra_data (mem_a_data),
		.i_rb_addr (addr_q[BADDR_W-1:2]),
		.o_rb_data (mem_b_data),
		.i_we      (mem_we),
		.i_waddr   (mem_waddr),
		.i_wdata   (mem_wdata)
	);

	// read port: check at request, data one cycle later, answer registered
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rq_valid_q <= 1'b0;
			rq_deny_q  <= 1'b0;
			rsp_q      <= '0;
		end else begin
			rq_valid_q <= i_rd_req.valid;
			rq_deny_q  <= i_rd_req.valid && !i_rd_req.fetch &&
				(prot_eff[i_rd_req.addr[BADDR_W-1 -: PBLK_W]] == prot_fetch_only);
			rsp_q.valid  <= rq_valid_q;
			rsp_q.denied <= rq_deny_q;
			rsp_q.data   <= rq_deny_q ? 32'h00000000 : mem_a_data; // hides protected data
		end
	end

	// sticky flags: a set in the clearing cycle wins
	logic [1:0] flg_set, flg_clr;
	assign flg_set[FLG_ACC]  = (rq_valid_q && rq_deny_q) || refuse;
	assign flg_set[FLG_DONE] = (st_q == st_wait) && (st_d == st_idle) && op_flash_q;
	assign flg_clr = (wr_go && (awaddr_q == OFS_IRAW)) ? wd[1:0] : 2'b00;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			raw_q <= '0;
			irq_q <= 1'b0;
		end else begin
			raw_q <= (raw_q & ~flg_clr) | flg_set;
			irq_q <= |(raw_q & msk_q);
		end
	end

	assign o_awready = awready_q;
	assign o_wready  = wready_q;
	assign o_bvalid  = bvalid_q;
	assign o_bresp   = bresp_q;
	assign o_arready = arready_q;
	assign o_rvalid  = rvalid_q;
	assign o_rdata   = rdata_q;
	assign o_rresp   = rresp_q;
	assign o_rd_rsp  = rsp_q;
	assign o_busy    = busy_q;
	assign o_irq     = irq_q;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// array read back two cycles after the write, so the stored word is checked
	a_prog_and_merge: assert property (((st_q == st_pwr) ##1 $stable(addr_q) [*2]) |->
		(mem_b_data == ($past(mem_b_data, 2) & $past(data_q, 2))))
		else $error("program word is not the AND of new and old");
	a_no_zero_rise: assert property (((st_q == st_pwr) ##1 $stable(addr_q) [*2]) |->
		((mem_b_data & ~$past(mem_b_data, 2)) == 32'h0))
		else $error("program raised a cleared bit");
	a_refuse_locked: assert property (refuse |=>
		((st_q == st_idle) && raw_q[FLG_ACC] && err_q))
		else $error("erase or program ran on a locked block");
	a_fetch_only_deny: assert property ((i_rd_req.valid && !i_rd_req.fetch &&
		(prot_eff[i_rd_req.addr[BADDR_W-1 -: PBLK_W]] == prot_fetch_only)) |->
		##2 (o_rd_rsp.valid && o_rd_rsp.denied))
		else $error("data read of fetch-only block not denied");
	a_fetch_served: assert property ((i_rd_req.valid && i_rd_req.fetch) |->
		##2 (o_rd_rsp.valid && !o_rd_rsp.denied))
		else $error("instruction fetch was denied");
	// block 1 is the one that software tightens
	a_prot_tighten: assert property (##1 (prot_eff[1] >= $past(prot_eff[1])))
		else $error("protection loosened without reset");
	a_usec_readback: assert property ((ar_take && (i_araddr == OFS_USEC)) |=>
		(o_rdata == {24'h000000, usec_q}))
		else $error("clocks per microsecond read back wrong");
	a_busy_in_op: assert property ((go_prog || go_erase) |=>
		(o_busy throughout (st_q != st_idle) [*2]))
		else $error("busy not shown during an operation");
	a_done_flag: assert property (((st_q == st_wait) && (st_d == st_idle) && op_flash_q) |=>
		raw_q[FLG_DONE])
		else $error("completion did not set the done flag");
	a_irq_gate: assert property (##1 (o_irq == |($past(raw_q) & $past(msk_q))))
		else $error("interrupt does not follow enabled flags");
	a_user_locked: assert property (usaved_q |=>
		($stable(user_nv_q[0]) && $stable(user_nv_q[1])))
		else $error("committed user register changed");
	a_prot_commit: assert property (psave_go |=> (prot_nv_q[1] == $past(prot_eff[1])))
		else $error("protection commit did not copy the setting");

	c_program_done: cover property ((st_q == st_pwr) ##[1:40] raw_q[FLG_DONE]);
	c_erase_run: cover property ((st_q == st_erase) [*8]);
	c_fetch_only_hit: cover property (o_rd_rsp.valid && o_rd_rsp.denied);
	c_irq_raised: cover property (!o_irq ##1 o_irq);
endmodule // fppc_ctrl
`default_nettype wire

// file: src/fppc_pkg.sv
/*
 * fppc_pkg: shared constants and types of the flash program and protection controller.
 * Assumes a single 10 MHz system clock and 32-bit AXI4-Lite register access.
 */
package fppc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // command and status
	localparam logic [7:0] OFS_ADDR = 8'h04; // flash byte address
	localparam logic [7:0] OFS_DATA = 8'h08; // program data word
	localparam logic [7:0] OFS_USEC = 8'h0c; // clocks per microsecond
	localparam logic [7:0] OFS_PSEL = 8'h10; // protection block select
	localparam logic [7:0] OFS_PROT = 8'h14; // protection of selected block
	localparam logic [7:0] OFS_IRAW = 8'h18; // raw flags, write one to clear
	localparam logic [7:0] OFS_IMSK = 8'h1c; // interrupt enables
	localparam logic [7:0] OFS_IMIS = 8'h20; // masked flags
	localparam logic [7:0] OFS_USR0 = 8'h24; // user register 0
	localparam logic [7:0] OFS_USR1 = 8'h28; // user register 1
	// control bits (write) and status bits (read) of OFS_CTRL
	localparam int CTL_PROG   = 0;
	localparam int CTL_ERASE  = 1;
	localparam int CTL_PSAVE  = 2;
	localparam int CTL_USAVE  = 3;
	localparam int STA_BUSY   = 8;
	localparam int STA_ERR    = 9;
	localparam int STA_PSAVED = 10;
	localparam int STA_USAVED = 11;
	// flag bit positions
	localparam int FLG_ACC  = 0; // invalid_access_flag
	localparam int FLG_DONE = 1; // op_done_flag
	// geometry: 16 kB array, 1 kB erase blocks, 2 kB protection blocks
	localparam int WORDS     = 4096;
	localparam int BADDR_W   = 14;
	localparam int WADDR_W   = 12;
	localparam int PROT_BLKS = 8;
	localparam int PBLK_W    = 3;
	localparam int EIDX_W    = 8;
	// timing
	localparam int          CLK_MHZ  = 10;
	localparam logic [7:0]  USEC_RST = 8'(CLK_MHZ);
	localparam logic [15:0] PROG_TIME_US  = 16'h0001;
	localparam logic [15:0] ERASE_TIME_US = 16'h0002;
	localparam logic [15:0] SAVE_TIME_US  = 16'h0001;
	// reset values
	localparam logic [31:0] ERASED_WORD = 32'hffffffff;
	localparam logic [31:0] USER_RST    = 32'hffffffff;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ordered by strictness, so a larger code is tighter
	typedef enum logic [1:0] {
		prot_full_access = 2'b00,
		prot_no_modify   = 2'b01,
		prot_fetch_only  = 2'b10
	} fppc_prot_type;

	typedef enum logic [2:0] {
		st_idle  = 3'b000,
		st_prd   = 3'b001,
		st_pwr   = 3'b010,
		st_erase = 3'b011,
		st_wait  = 3'b100
	} fppc_state_type;

	// read request from instruction fetch or data side (core or debugger)
	typedef struct packed {
		logic               valid;
		logic               fetch;
		logic [BADDR_W-1:0] addr;
	} fppc_rd_req_type;

	typedef struct packed {
		logic        valid;
		logic        denied;
		logic [31:0] data;
	} fppc_rd_rsp_type;
endpackage

// file: src/fppc_mem.sv
/*
 * fppc_mem: flash array model, two registered read ports and one write port.
 * A read of a word in the cycle that writes it returns the old word.
 */
`timescale 1ns/1ps
`default_nettype none
module fppc_mem
	import fppc_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic [WADDR_W-1:0] i_ra_addr,
	output logic      [31:0]        o_ra_data,
	input  wire logic [WADDR_W-1:0] i_rb_addr,
	output logic      [31:0]        o_rb_data,
	input  wire logic               i_we,
	input  wire logic [WADDR_W-1:0] i_waddr,
	input  wire logic [31:0]        i_wdata
);
	logic [31:0] mem [WORDS]; // array cells

	// array starts erased
	initial begin
		for (int i = 0; i < WORDS; i++) begin
			mem[i] = ERASED_WORD;
		end
	end

	// write port
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// read ports, data from registers
	always_ff @(posedge i_clk) begin
		o_ra_data <= mem[i_ra_addr];
		o_rb_data <= mem[i_rb_addr];
	end
endmodule // fppc_mem
`default_nettype wire

// file: bench/fppc_core_model.sv
/*
 * fppc_core_model: stand-in for the core fetch and data read side.
 * Assumes the controller takes one request a cycle on the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fppc_core_model
	import fppc_pkg::*;
(
	input  wire logic          i_clk,
	output var fppc_rd_req_type o_req
);
	initial o_req = '0; // idle until the bench asks

	// one-cycle request, word aligned only
	task automatic issue(input logic [BADDR_W-1:0] a, input logic f);
		o_req <= '{valid: 1'b1, fetch: f, addr: {a[BADDR_W-1:2], 2'b00}};
		@(posedge i_clk);
		// released lines must not keep the old address
		o_req <= '{valid: 1'b0, fetch: ~f, addr: ~a};
	endtask
endmodule // fppc_core_model
`default_nettype wire

// file: bench/tb.sv
/*
 * tb: self-checking bench of fppc_ctrl over AXI4-Lite and the read port.
 * Assumes the core model drives reads; expected values queue up.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fppc_pkg::*;
	logic            clk, rst_n, por_n;        // clock, resets
	logic            awv, wv, bready, arv, rready; // master side
	logic            awr, wrdy, bv, arr, rv, busy, irq; // slave side
	logic [7:0]      awaddr, araddr, us;       // offsets, clocks per us
	logic [31:0]     wdata, rdata, d1, d2;     // bus and program words
	logic [1:0]      bresp, rresp;             // response codes
	logic [13:0]     pa;                       // program byte address
	fppc_rd_req_type req;                      // core read request
	fppc_rd_rsp_type rsp;                      // flash read answer
	logic [33:0]     rq[$];                    // notes for register reads
	logic [32:0]     fq[$];                    // notes for flash reads
	logic [1:0]      bq[$];                    // notes for write answers
	int              miscompares, checks_done; // tallies

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	fppc_ctrl i_fppc_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
		.i_awvalid(awv), .o_awready(awr), .i_awaddr(awaddr), .i_wvalid(wv),
		.o_wready(wrdy), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bv),
		.i_bready(bready), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
		.i_araddr(araddr), .o_rvalid(rv), .i_rready(rready), .o_rdata(rdata),
		.o_rresp(rresp), .i_rd_req(req), .o_rd_rsp(rsp), .o_busy(busy),
		.o_irq(irq));
	fppc_core_model i_fppc_core_model (.i_clk(clk), .o_req(req));

	task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] s);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	// one compare per kind of result; register, response and flash answers sampled at the answer edge
	task automatic cmp_reg(input logic [33:0] e);
		cmp("reg", e, {rresp, rdata});
	endtask
	task automatic cmp_resp(input logic [1:0] e);
		cmp("resp", {32'h0, e}, {32'h0, bresp});
	endtask
	task automatic cmp_flash(input logic [32:0] e);
		cmp("flash", {1'b0, e}, {1'b0, rsp.denied, rsp.data});
	endtask
	task automatic cmp_busy(input logic e);
		cmp("busy", {33'h0, e}, {33'h0, busy});
	endtask
	task automatic cmp_irq(input logic e);
		cmp("irq", {33'h0, e}, {33'h0, irq});
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// a wait that ran out ends the run
	task automatic tmo(input int n);
		if (n >= 400) begin
			miscompares++;
			give_verdict();
		end
	endtask

	// results are compared as they appear, oldest note first
	always @(posedge clk) begin
		if (rv && rready) cmp_reg(rq.pop_front());
		if (bv && bready) cmp_resp(bq.pop_front());
		if (rsp.valid) cmp_flash(fq.pop_front());
	end

	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic ap, dp, bp; // address, data, answer still pending
		ap = 1'b1;
		dp = 1'b1;
		bp = 1'b1;
		bq.push_back(a > OFS_USR1 ? RESP_SLVERR : RESP_OKAY);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		// pending bits, not the strobes, since those update only after this step
		for (n = 0; n < 400 && (ap || dp || bp); n++) begin
			@(posedge clk);
			if (ap && awr) begin
				ap = 1'b0;
				awv <= 1'b0;
			end
			if (dp && wrdy) begin
				dp = 1'b0;
				wv <= 1'b0;
			end
			if (bp && bv) begin
				bp = 1'b0;
				bready <= 1'b0;
			end
		end
		@(posedge clk); // bready rests a cycle before the next write
		tmo(n);
	endtask

	// read: offsets past the last register expect an error answer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		int   n;
		logic ap, rp; // address, data still pending
		rq.push_back({a > OFS_USR1 ? RESP_SLVERR : RESP_OKAY, e});
		ap = 1'b1;
		rp = 1'b1;
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 400 && (ap || rp); n++) begin
			@(posedge clk);
			if (ap && arr) begin
				ap = 1'b0;
				arv <= 1'b0;
			end
			if (rp && rv) begin
				rp = 1'b0;
				rready <= 1'b0;
			end
		end
		@(posedge clk); // rready rests a cycle before the next read
		tmo(n);
	endtask

	// busy must match the expectation, then drop within the bound
	task automatic idle(input logic eb);
		int n;
		@(posedge clk);
		cmp_busy(eb);
		for (n = 0; n < 400 && busy; n++) @(posedge clk);
		tmo(n);
	endtask

	// one flash read through the core model, spaced by a cycle
	task automatic fl(input logic [13:0] a, input logic f, input logic [32:0] e);
		fq.push_back(e);
		i_fppc_core_model.issue(a, f);
		@(posedge clk);
	endtask

	// chip reset, with power-on reset too when asked
	task automatic reset(input logic p);
		rst_n <= 1'b0;
		por_n <= ~p;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		@(posedge clk);
	endtask

	initial begin
		{rst_n, por_n, awv, wv, bready, arv, rready} = 7'h0;
		{awaddr, araddr, wdata} = 48'h0;
		miscompares = 0;
		checks_done = 0;
		void'($urandom(32'hfa8606bb));
		d1 = $urandom;
		d2 = $urandom;
		us = 8'($urandom_range(15, 1));
		pa = 14'($urandom_range(255) * 4); // inside the first erase block
		reset(1'b1);
		rd(OFS_USEC, {24'h0, USEC_RST});
		rd(OFS_USR0, USER_RST);
		rd(8'h40, 32'h0);
		wr(8'h40, 32'h0);
		wr(OFS_USEC, {24'h0, us});
		rd(OFS_USEC, {24'h0, us});
		wr(OFS_ADDR, {18'h0, pa});
		wr(OFS_DATA, d1);
		wr(OFS_CTRL, 32'h1);
		idle(1'b1);
		fl(pa, 1'b0, {1'b0, d1});
		wr(OFS_DATA, d2);
		wr(OFS_CTRL, 32'h1);
		idle(1'b1);
		fl(pa, 1'b0, {1'b0, d1 & d2});
		rd(OFS_IRAW, 32'h2);
		wr(OFS_CTRL, 32'h2);
		idle(1'b1);
		fl(pa, 1'b1, {1'b0, ERASED_WORD});
		fl(pa ^ 14'h3fc, 1'b0, {1'b0, ERASED_WORD});
		wr(OFS_IRAW, 32'h3);
		wr(OFS_PSEL, 32'h1);
		wr(OFS_PROT, 32'h1);
		rd(OFS_PROT, 32'h1);
		wr(OFS_ADDR, 32'h800);
		wr(OFS_CTRL, 32'h1);
		idle(1'b0);
		rd(OFS_CTRL, 32'h200);
		wr(OFS_CTRL, 32'h2);
		idle(1'b0);
		rd(OFS_IRAW, 32'h1);
		fl(14'h800, 1'b0, {1'b0, ERASED_WORD});
		wr(OFS_PROT, 32'h0);
		rd(OFS_PROT, 32'h1);
		wr(OFS_PROT, 32'h2);
		rd(OFS_PROT, 32'h2);
		wr(OFS_PROT, 32'h1);
		rd(OFS_PROT, 32'h2);
		wr(OFS_IRAW, 32'h3);
		fl(14'h804, 1'b1, {1'b0, ERASED_WORD});
		fl(14'h804, 1'b0, {1'b1, 32'h0});
		repeat (3) @(posedge clk);
		rd(OFS_IRAW, 32'h1);
		rd(OFS_IMIS, 32'h0);
		cmp_irq(1'b0);
		wr(OFS_IMSK, 32'h1);
		rd(OFS_IMIS, 32'h1);
		repeat (2) @(posedge clk);
		cmp_irq(1'b1);
		wr(OFS_IRAW, 32'h1);
		repeat (2) @(posedge clk);
		cmp_irq(1'b0);
		// chip reset drops uncommitted protection
		reset(1'b0);
		wr(OFS_PSEL, 32'h1);
		rd(OFS_PROT, 32'h0);
		wr(OFS_PROT, 32'h1);
		wr(OFS_CTRL, 32'h4);
		idle(1'b1);
		reset(1'b0);
		wr(OFS_PSEL, 32'h1);
		rd(OFS_PROT, 32'h1);
		rd(OFS_CTRL, 32'h400);
		wr(OFS_USR0, d1);
		wr(OFS_USR1, d2);
		rd(OFS_USR0, d1);
		rd(OFS_USR1, d2);
		wr(OFS_CTRL, 32'h8);
		idle(1'b1);
		reset(1'b0);
		wr(OFS_USR1, ~d2);
		rd(OFS_USR0, d1);
		rd(OFS_USR1, d2);
		rd(OFS_CTRL, 32'hc00);
		@(posedge clk);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
